// ---- rtl/ext_int_pkg.sv ----
/*
  Package for the external interrupt sense and flag block: register
  offsets, field positions, reset values, sense encodings and carriers.
  Assumes a 32-bit AXI4-Lite register bus with one register per word.
*/
package ext_int_pkg;

  localparam int NUM_INPUTS_MAX = 16;

  // Byte offsets of the register words.
  localparam logic [7:0] OFS_INT_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_SENSE_HIGH   = 8'h04;
  localparam logic [7:0] OFS_SENSE_LOW    = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h14;
  localparam logic [7:0] OFS_PRIORITY_0   = 8'h20;
  localparam int         NUM_PRIO_REGS    = 4;

  // Reset values.
  localparam logic [15:0] RST_INT_ENABLE  = 16'h0000;
  localparam logic [15:0] RST_SENSE       = 16'h0000;
  localparam logic [15:0] RST_INT_STATUS  = 16'h0000;
  localparam logic [2:0]  RST_PRIO_FIELD  = 3'h7;
  localparam logic [15:0] PRIO_FIELD_MASK = 16'h7777;
  localparam logic [1:0]  RST_IRQ_BITS    = 2'h0;

  // Priority field layout: four fields, lsb at 0, 4, 8 and 12.
  localparam int PRIO_FIELD_STRIDE = 4;
  localparam int PRIO_PER_REG      = 4;

  // Own event bits of the block-level interrupt status.
  localparam int EVT_FLAG_SET  = 0;
  localparam int EVT_OVERRUN   = 1;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW_LEVEL = 2'h0,
    SENSE_FALLING   = 2'h1,
    SENSE_RISING    = 2'h2,
    SENSE_BOTH      = 2'h3
  } sense_mode_e;

  // Per-input acknowledge from the exception logic and the transfer
  // controller.
  typedef struct packed {
    logic [NUM_INPUTS_MAX-1:0] exc_taken;
    logic [NUM_INPUTS_MAX-1:0] xfer_taken;
    logic [NUM_INPUTS_MAX-1:0] xfer_int_disable_sel;
  } ack_s;

endpackage

// ---- rtl/external_int_sense_flags.sv ----
/*
  External interrupt front end: input synchronisers, sense selection,
  request flags with clear rules, enable gating, priority fields, and an
  AXI4-Lite register slave with a block-level interrupt.
  Assumes that request inputs are asynchronous pins and that acknowledge
  strobes come from logic on clk_in, one cycle each.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Priority code 000 lowest, 111 highest; reset ones.
// - Per-input enable bit gates request; reset zero.
// - Eight-input variant: upper bits reserved, read zero; priority fields of inputs 15..8 still reset to 7 and take writes.
// - Sense 00: request while input low.
// - Sense 01: request on falling edge.
// - Sense 10: request on rising edge.
// - Sense 11: request on either edge.
// - Two sense registers, two bits per input.
// - Flag set on selected condition; resets zero.
// - Flag cleared by writing zero after reading one.
// - Level mode: exception handling clears flag if high.
// - Edge modes: exception handling clears flag.
// - Transfer activation clears flag when disable-select zero.
// - Writing one to a flag is ignored.
// - Four three-bit priority fields per register.
// - Reserved priority bits read zero, writes ignored.
module external_int_sense_flags #(
  parameter int NUM_INPUTS = 16
) (
  // Clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  // External request pins, active low
  input  wire logic [NUM_INPUTS-1:0]               ext_request_input_n_in,
  // Acknowledges from exception logic and transfer controller
  input  wire ext_int_pkg::ack_s                   ack_in,
  // Requests and priorities toward exception logic
  output logic [NUM_INPUTS-1:0]                    request_out,
  output logic [3*NUM_INPUTS-1:0]                  priority_out,
  // AXI4-Lite write address
  input  wire logic                                s_axi_awvalid_in,
  output logic                                     s_axi_awready_out,
  input  wire logic [7:0]                          s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire logic                                s_axi_wvalid_in,
  output logic                                     s_axi_wready_out,
  input  wire logic [31:0]                         s_axi_wdata_in,
  input  wire logic [3:0]                          s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic                                     s_axi_bvalid_out,
  input  wire logic                                s_axi_bready_in,
  output logic [1:0]                               s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic                                s_axi_arvalid_in,
  output logic                                     s_axi_arready_out,
  input  wire logic [7:0]                          s_axi_araddr_in,
  // AXI4-Lite read data
  output logic                                     s_axi_rvalid_out,
  input  wire logic                                s_axi_rready_in,
  output logic [31:0]                              s_axi_rdata_out,
  output logic [1:0]                               s_axi_rresp_out,
  // Block interrupt
  output logic                                     irq_out
);
  import ext_int_pkg::*;

  // Only the full and the reduced variant have a register layout.
  if (NUM_INPUTS != 8 && NUM_INPUTS != 16) begin : g_bad_inputs
    $error("NUM_INPUTS must be 8 or 16");
  end

  localparam int NI = NUM_INPUTS_MAX;
  // Inputs beyond NUM_INPUTS are reserved in the reduced variant.
  localparam logic [NI-1:0] IN_MASK =
    (NUM_INPUTS == NI) ? 16'hFFFF : 16'h00FF;

  logic [NI-1:0]   pin_meta_r;
  logic [NI-1:0]   pin_sync_r;
  logic [NI-1:0]   pin_prev_r;
  logic [NI-1:0]   ext_int_enable_r;
  logic [15:0]     ext_sense_high_r;
  logic [15:0]     ext_sense_low_r;
  logic [NI-1:0]   ext_int_status_r;
  logic [NI-1:0]   ext_int_status_nxt;
  logic [NI-1:0]   read_one_r;
  logic [NI-1:0]   set_cond;
  logic [NI-1:0]   hw_clear;
  logic [NI-1:0]   sw_clear;
  logic [NI-1:0]   pins_ext;
  logic [15:0]     priority_level_r [NUM_PRIO_REGS];
  logic [1:0]      irq_status_r;
  logic [1:0]      irq_mask_r;
  logic [NI-1:0]   req_all;
  logic [1:0]      irq_evt;

  // Bus handshake state.
  logic            aw_held_r;
  logic            w_held_r;
  logic [7:0]      aw_addr_r;
  logic [31:0]     w_data_r;
  logic [3:0]      w_strb_r;
  logic            wr_fire;
  logic            rd_fire;
  logic            wr_hit;
  logic            rd_hit;
  logic [31:0]     rd_word;

  always_comb begin
    pins_ext = '1;
    pins_ext[NUM_INPUTS-1:0] = ext_request_input_n_in;
  end

  // Pins are asynchronous; two stages before any logic looks at them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta_r <= '1;
      pin_sync_r <= '1;
      pin_prev_r <= '1;
    end else begin
      pin_meta_r <= pins_ext;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++) begin : g_in
      sense_mode_e mode;
      logic        fall;
      logic        rise;
      // Upper register holds inputs 15..8, lower 7..0, B bit on top.
      // Both selects stay in range for every input number.
      assign mode = (gi >= 8) ?
        sense_mode_e'(ext_sense_high_r[2*(gi%8) +: 2]) :
        sense_mode_e'(ext_sense_low_r[2*(gi%8) +: 2]);
      assign fall = pin_prev_r[gi] & ~pin_sync_r[gi];
      assign rise = ~pin_prev_r[gi] & pin_sync_r[gi];
      always_comb begin
        unique case (mode)
          SENSE_LOW_LEVEL: set_cond[gi] = ~pin_sync_r[gi];
          SENSE_FALLING:   set_cond[gi] = fall;
          SENSE_RISING:    set_cond[gi] = rise;
          SENSE_BOTH:      set_cond[gi] = fall | rise;
        endcase
        if (mode == SENSE_LOW_LEVEL) begin
          // Only clears when the pin has already gone back high.
          hw_clear[gi] = ack_in.exc_taken[gi] & pin_sync_r[gi];
        end else begin
          hw_clear[gi] = ack_in.exc_taken[gi];
        end
        if (ack_in.xfer_taken[gi] && !ack_in.xfer_int_disable_sel[gi]) begin
          hw_clear[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // Bus write and read fire conditions.
  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid_out;
  assign rd_fire = s_axi_arvalid_in & s_axi_arready_out;

  always_comb begin
    sw_clear = '0;
    if (wr_fire && aw_addr_r == OFS_INT_STATUS) begin
      // Zero bits clear only flags that were read as one; ones ignored.
      sw_clear = ~{w_data_r[15:8] | {8{~w_strb_r[1]}},
                   w_data_r[7:0]  | {8{~w_strb_r[0]}}}
                 & read_one_r;
    end
  end

  // A set in the same cycle as a clear wins so no event is lost.
  always_comb begin
    ext_int_status_nxt = ((ext_int_status_r & ~(sw_clear | hw_clear))
                         | set_cond) & IN_MASK;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_int_status_r <= RST_INT_STATUS;
    end else begin
      ext_int_status_r <= ext_int_status_nxt;
    end
  end

  // Remember which flags software has seen as one.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      read_one_r <= '0;
    end else if (rd_fire && s_axi_araddr_in == OFS_INT_STATUS) begin
      read_one_r <= ext_int_status_r;
    end else begin
      read_one_r <= read_one_r & ext_int_status_nxt;
    end
  end

  assign req_all     = ext_int_status_r & ext_int_enable_r & IN_MASK;
  assign request_out = req_all[NUM_INPUTS-1:0];

  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_prio
      // Binary code is the level directly: 0 lowest, 7 highest.
      assign priority_out[3*gi +: 3] =
        priority_level_r[gi / PRIO_PER_REG]
          [PRIO_FIELD_STRIDE*(3 - gi % PRIO_PER_REG) +: 3];
    end
  endgenerate

  // Write channel capture; address and data may arrive in either order.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready_out = ~aw_held_r & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_held_r & ~s_axi_bvalid_out;

  always_comb begin
    wr_hit = (aw_addr_r == OFS_INT_ENABLE) || (aw_addr_r == OFS_SENSE_HIGH)
          || (aw_addr_r == OFS_SENSE_LOW)  || (aw_addr_r == OFS_INT_STATUS)
          || (aw_addr_r == OFS_IRQ_STATUS) || (aw_addr_r == OFS_IRQ_MASK)
          || (aw_addr_r[7:4] == OFS_PRIORITY_0[7:4]
              && aw_addr_r[1:0] == 2'h0);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Control registers, sixteen bits in the low two byte lanes; the interrupt mask is two bits in lane 0.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_int_enable_r <= RST_INT_ENABLE;
      ext_sense_high_r <= RST_SENSE;
      ext_sense_low_r  <= RST_SENSE;
      irq_mask_r       <= RST_IRQ_BITS;
    end else if (wr_fire) begin
      for (int b = 0; b < 2; b++) begin
        if (w_strb_r[b]) begin
          if (aw_addr_r == OFS_INT_ENABLE) begin
            ext_int_enable_r[8*b +: 8] <= w_data_r[8*b +: 8]
                                          & IN_MASK[8*b +: 8];
          end
          if (aw_addr_r == OFS_SENSE_HIGH && NUM_INPUTS == NI) begin
            ext_sense_high_r[8*b +: 8] <= w_data_r[8*b +: 8];
          end
          if (aw_addr_r == OFS_SENSE_LOW) begin
            ext_sense_low_r[8*b +: 8] <= w_data_r[8*b +: 8];
          end
        end
      end
      if (aw_addr_r == OFS_IRQ_MASK && w_strb_r[0]) begin
        irq_mask_r <= w_data_r[1:0];
      end
    end
  end

  generate
    for (gi = 0; gi < NUM_PRIO_REGS; gi++) begin : g_preg
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          priority_level_r[gi] <= {4{1'b0, RST_PRIO_FIELD}};
        end else if (wr_fire && aw_addr_r == OFS_PRIORITY_0
                     + 8'(PRIO_FIELD_STRIDE * gi)) begin
          for (int b = 0; b < 2; b++) begin
            if (w_strb_r[b]) begin
              // Reserved bits stay zero whatever is written.
              priority_level_r[gi][8*b +: 8] <= w_data_r[8*b +: 8]
                & PRIO_FIELD_MASK[8*b +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // Block interrupt: flag-set events and an edge landing on a set flag.
  always_comb begin
    irq_evt = 2'h0;
    irq_evt[EVT_FLAG_SET] = |(set_cond & ~ext_int_status_r & IN_MASK);
    // An edge that finds its flag already set would otherwise go unseen.
    irq_evt[EVT_OVERRUN]  = |(set_cond & ext_int_status_r & IN_MASK
                              & (pin_prev_r ^ pin_sync_r));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_status_r <= RST_IRQ_BITS;
    end else begin
      for (int e = 0; e < 2; e++) begin
        // An event in the cycle of its clear wins.
        if (irq_evt[e]) begin
          irq_status_r[e] <= 1'b1;
        end else if (wr_fire && aw_addr_r == OFS_IRQ_STATUS
                     && w_strb_r[0] && w_data_r[e]) begin
          irq_status_r[e] <= 1'b0;
        end
      end
    end
  end

  assign irq_out = |(irq_status_r & irq_mask_r);

  // Read path.
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr_in == OFS_INT_ENABLE) begin
      rd_word[15:0] = ext_int_enable_r;
    end else if (s_axi_araddr_in == OFS_SENSE_HIGH) begin
      rd_word[15:0] = ext_sense_high_r;
    end else if (s_axi_araddr_in == OFS_SENSE_LOW) begin
      rd_word[15:0] = ext_sense_low_r;
    end else if (s_axi_araddr_in == OFS_INT_STATUS) begin
      rd_word[15:0] = ext_int_status_r;
    end else if (s_axi_araddr_in == OFS_IRQ_STATUS) begin
      rd_word[1:0] = irq_status_r;
    end else if (s_axi_araddr_in == OFS_IRQ_MASK) begin
      rd_word[1:0] = irq_mask_r;
    end else if (s_axi_araddr_in[7:4] == OFS_PRIORITY_0[7:4]
                 && s_axi_araddr_in[1:0] == 2'h0) begin
      rd_word[15:0] = priority_level_r[s_axi_araddr_in[3:2]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready_out = ~s_axi_rvalid_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_word;
      s_axi_rresp_out  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/ext_int_source_model.sv ----
/* Model of the request sources and the exception logic facing the block.
   Assumes pull, let-go and transfer commands from the bench arrive as one-cycle pulses on clk_in; accept_in is held as a level. */
`timescale 1ns/1ps
`default_nettype none
module ext_int_source_model (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  // Bench commands
  input  wire logic [15:0]   pull_low_in,
  input  wire logic [15:0]   let_go_in,
  input  wire logic          accept_in,
  input  wire logic [15:0]   xfer_in,
  input  wire logic [15:0]   xfer_dis_in,
  // Block side
  input  wire logic [15:0]   request_in,
  output logic [15:0]        pins_n_out,
  output ext_int_pkg::ack_s  ack_out
);
  import ext_int_pkg::*;
  logic [15:0] low_r;
  logic [15:0] grant;

  // Lowest pending input is taken; never twice in a row on one input.
  assign grant = accept_in ? (request_in & (~request_in + 16'h0001)) :
                 16'h0000;
  assign pins_n_out = ~low_r;

  // A pin stays low until its handling starts or let_go_in releases it, then goes high.
  always_ff @(posedge clk_in) begin
    if (rst_in)
      low_r <= 16'h0000;
    else
      low_r <= (low_r | pull_low_in) & ~let_go_in & ~grant;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in)
      ack_out <= '0;
    else
      ack_out <= {grant & ~ack_out.exc_taken, xfer_in, xfer_dis_in};
  end
endmodule
`default_nettype wire

// ---- tb/external_int_sense_flags_assertions.sv ----
/* Port-level checker for the external interrupt block.
   Assumes one clock and the synchronous reset of the block. */
`timescale 1ns/1ps
`default_nettype none
module external_int_sense_flags_assertions #(
  parameter int NUM_INPUTS = 16
) (
  // Clock, reset, pins and acknowledges
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic [NUM_INPUTS-1:0]   ext_request_input_n_in,
  input wire ext_int_pkg::ack_s       ack_in,
  // Requests, priorities and interrupt
  input wire logic [NUM_INPUTS-1:0]   request_out,
  input wire logic [3*NUM_INPUTS-1:0] priority_out,
  input wire logic                    irq_out,
  // Register bus
  input wire logic                    s_axi_awvalid_in,
  input wire logic                    s_axi_awready_out,
  input wire logic [7:0]              s_axi_awaddr_in,
  input wire logic                    s_axi_wvalid_in,
  input wire logic                    s_axi_wready_out,
  input wire logic [31:0]             s_axi_wdata_in,
  input wire logic [3:0]              s_axi_wstrb_in,
  input wire logic                    s_axi_bvalid_out,
  input wire logic                    s_axi_bready_in,
  input wire logic [1:0]              s_axi_bresp_out,
  input wire logic                    s_axi_arvalid_in,
  input wire logic                    s_axi_arready_out,
  input wire logic [7:0]              s_axi_araddr_in,
  input wire logic                    s_axi_rvalid_out,
  input wire logic                    s_axi_rready_in,
  input wire logic [31:0]             s_axi_rdata_out,
  input wire logic [1:0]              s_axi_rresp_out
);
  import ext_int_pkg::*;
  localparam int N = NUM_INPUTS;
  logic [3*N-1:0] hist_r;
  logic [N-1:0]   quiet;
  logic [N-1:0]   clr;

  // A pin high for four samples cannot raise a set event in any mode.
  always_ff @(posedge clk_in) begin
    if (rst_in)
      hist_r <= '1;
    else
      hist_r <= {hist_r[2*N-1:0], ext_request_input_n_in};
  end
  assign quiet = ext_request_input_n_in & hist_r[N-1:0] &
                 hist_r[2*N-1:N] & hist_r[3*N-1:2*N];
  assign clr = (ack_in.exc_taken[N-1:0] | (ack_in.xfer_taken[N-1:0] &
               ~ack_in.xfer_int_disable_sel[N-1:0])) & quiet;

  a_reset_values: assert property (@(posedge clk_in)
    rst_in |=> request_out == '0 && priority_out == '1 && !irq_out)
    else $error("outputs not at reset values");
  a_prio_write_only: assert property (@(posedge clk_in)
    disable iff (rst_in) $changed(priority_out) |-> $past(!s_axi_awready_out))
    else $error("priority changed without a write");
  a_ack_clears_flag: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (clr != '0) |=> (request_out & $past(clr)) == '0)
    else $error("acknowledge left a request standing");
  a_b_after_write: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out)
    else $error("write response missing");
  a_r_after_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data missing");
  a_b_blocks_write: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while response pending");
  a_r_blocks_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while data pending");
  a_b_holds_resp: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  a_r_holds_data: assert property (@(posedge clk_in) disable iff (rst_in)
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
endmodule
bind external_int_sense_flags external_int_sense_flags_assertions #(
  .NUM_INPUTS(NUM_INPUTS)
) i_external_int_sense_flags_assertions (
  .clk_in(clk_in), .rst_in(rst_in), .ack_in(ack_in),
  .ext_request_input_n_in(ext_request_input_n_in), .irq_out(irq_out),
  .request_out(request_out), .priority_out(priority_out),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_wdata_in(s_axi_wdata_in),
  .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out));
`default_nettype wire

// ---- tb/external_int_sense_flags_tb.sv ----
/* Self-checking bench: register bus tasks, pins and acknowledges.
   Assumes the source model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module external_int_sense_flags_tb;
  import ext_int_pkg::*;
  logic        clk_in, rst_in, accept, irq;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] pull, go, xfer, dis, pins_n, req;
  logic [47:0] prio;
  ack_s        ack;
  int          n_errors, total_checks;

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  ext_int_source_model i_ext_int_source_model (
    .clk_in(clk_in), .rst_in(rst_in), .pull_low_in(pull), .let_go_in(go),
    .accept_in(accept), .xfer_in(xfer), .xfer_dis_in(dis),
    .request_in(req), .pins_n_out(pins_n), .ack_out(ack));

  external_int_sense_flags i_external_int_sense_flags (
    .clk_in(clk_in), .rst_in(rst_in), .ext_request_input_n_in(pins_n),
    .ack_in(ack), .request_out(req), .priority_out(prio), .irq_out(irq),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Each task starts on a fresh edge so no signal is driven twice at once.
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
                    input logic [1:0] er);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] v);
    rd(a);
    chk(d, {16'h0000, v});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic pin(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge clk_in);
    pull <= lo;
    go <= hi;
    @(posedge clk_in);
    pull <= 16'h0000;
    go <= 16'h0000;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic xf(input logic [15:0] m, input logic [15:0] s);
    @(posedge clk_in);
    xfer <= m;
    dis <= s;
    @(posedge clk_in);
    xfer <= 16'h0000;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    final_report();
  end

  initial begin
    rst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, accept} = '0;
    {awaddr, araddr, wdata, pull, go, xfer, dis} = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(OFS_INT_ENABLE, 16'h0000);
    rdchk(OFS_SENSE_HIGH, 16'h0000);
    rdchk(OFS_SENSE_LOW, 16'h0000);
    rdchk(OFS_INT_STATUS, 16'h0000);
    for (int i = 0; i < NUM_PRIO_REGS; i++)
      rdchk(OFS_PRIORITY_0 + 8'(4 * i), 16'h7777);
    rd(8'h40);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h40, 16'hFFFF, RESP_SLVERR);
    $display("registers done");
    wr(OFS_PRIORITY_0, 16'hFFFF, RESP_OKAY);
    rdchk(OFS_PRIORITY_0, 16'h7777);
    wr(OFS_PRIORITY_0, 16'h0123, RESP_OKAY);
    rdchk(OFS_PRIORITY_0, 16'h0123);
    chk({20'h0, prio[11:0]}, {20'h0, 3'h3, 3'h2, 3'h1, 3'h0});
    $display("priority done");
    wr(OFS_SENSE_LOW, 16'h00E4, RESP_OKAY);
    wr(OFS_SENSE_HIGH, 16'h0001, RESP_OKAY);
    wr(OFS_INT_ENABLE, 16'h010F, RESP_OKAY);
    pin(16'h010E, 16'h0000);
    chk({16'h0, req}, 32'h0000010A);
    pin(16'h0000, 16'h010E);
    rdchk(OFS_INT_STATUS, 16'h010E);
    wr(OFS_INT_STATUS, 16'hFFFD, RESP_OKAY);
    rdchk(OFS_INT_STATUS, 16'h010C);
    wr(OFS_INT_STATUS, 16'h0000, RESP_OKAY);
    rdchk(OFS_INT_STATUS, 16'h0000);
    pin(16'h0008, 16'h0000);
    wr(OFS_INT_STATUS, 16'h0000, RESP_OKAY);
    rdchk(OFS_INT_STATUS, 16'h0008);
    // Release the pin so the transfer clear below meets a quiet input.
    pin(16'h0000, 16'h0008);
    wr(OFS_INT_ENABLE, 16'h0007, RESP_OKAY);
    chk({16'h0, req}, 32'h00000000);
    $display("sense done");
    chk({31'h0, irq}, 32'h00000000);
    wr(OFS_IRQ_MASK, 16'h0003, RESP_OKAY);
    chk({31'h0, irq}, 32'h00000001);
    rdchk(OFS_IRQ_STATUS, 16'h0003);
    wr(OFS_IRQ_STATUS, 16'h0003, RESP_OKAY);
    chk({31'h0, irq}, 32'h00000000);
    $display("irq done");
    wr(OFS_INT_ENABLE, 16'h000F, RESP_OKAY);
    xf(16'h0008, 16'h0008);
    rdchk(OFS_INT_STATUS, 16'h0008);
    xf(16'h0008, 16'h0000);
    rdchk(OFS_INT_STATUS, 16'h0000);
    $display("transfer done");
    accept <= 1'b1;
    pin(16'h0003, 16'h0000);
    repeat (10) @(posedge clk_in);
    chk({31'h0, irq}, 32'h00000001);
    rdchk(OFS_INT_STATUS, 16'h0000);
    $display("handling done");
    final_report();
  end
endmodule
`default_nettype wire
